//--- csrs_pkg.sv
// Constants, field layouts and types for the clock start-up reset sequencer.
// Assumes one reference clock; oscillator edges arrive as sampled pins.
package csrs_pkg;

    // Register byte offsets
    localparam logic [3:0] CSRS_OFS_CONFIG = 4'h0;
    localparam logic [3:0] CSRS_OFS_CONTROL = 4'h4;
    localparam logic [3:0] CSRS_OFS_STATUS = 4'h8;

    // Config register layout and value after reset
    localparam int CSRS_CFG_SRC_POS = 0;
    localparam int CSRS_CFG_SUT_POS = 4;
    localparam int CSRS_CFG_DIV_POS = 6;
    localparam logic [6:0] CSRS_CFG_RESET = 7'h22;

    // Control and status layout
    localparam int CSRS_CTL_SLEEP_POS = 0;
    localparam int CSRS_ST_STATE_POS = 0;
    localparam int CSRS_ST_RST_POS = 3;
    localparam int CSRS_ST_RANGE_POS = 4;
    localparam int CSRS_ST_TOUT_POS = 7;
    localparam int CSRS_ST_OSC_POS = 9;
    localparam int CSRS_ST_DIV_POS = 12;

    // Cycle counts of the watchdog and selected oscillators
    localparam int CSRS_TOUT_SHORT_CYC = 4096;
    localparam int CSRS_TOUT_LONG_CYC = 8192;
    localparam int CSRS_OSC_EXT_CYC = 6;
    localparam int CSRS_OSC_258_CYC = 258;
    localparam int CSRS_OSC_1K_CYC = 1024;
    localparam int CSRS_OSC_16K_CYC = 16384;
    localparam int CSRS_OSC_32K_CYC = 32768;
    localparam int CSRS_OSC_RST_EXTRA_CYC = 14;
    localparam int CSRS_DIV_LAST = 7;

    localparam logic [1:0] CSRS_RESP_OKAY = 2'h0;
    localparam logic [1:0] CSRS_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_HOLD = 3'h0,
        ST_TOUT = 3'h1,
        ST_OSC = 3'h2,
        ST_RUN = 3'h3,
        ST_SLEEP = 3'h4,
        ST_WAKE = 3'h5
    } csrs_state_type;

    typedef enum logic [1:0] {
        TO_NONE = 2'h0,
        TO_SHORT = 2'h1,
        TO_LONG = 2'h2
    } csrs_tout_type;

    typedef enum logic [2:0] {
        OC_6 = 3'h0,
        OC_258 = 3'h1,
        OC_1K = 3'h2,
        OC_16K = 3'h3,
        OC_32K = 3'h4
    } csrs_oscnt_type;

    // Raw fuse bits: a one is unprogrammed, a zero programmed
    typedef struct packed {
        logic divide_by_eight_option;
        logic [1:0] startup_time_bits;
        logic [3:0] clock_source_select;
    } csrs_cfg_type;

    typedef struct packed {
        csrs_tout_type tout;
        csrs_oscnt_type oscnt;
        logic [2:0] clock_range_select;
    } csrs_dec_type;

    function automatic csrs_dec_type csrs_decode(input csrs_cfg_type c);
        logic [2:0] key;
        logic [2:0] hi;
        csrs_dec_type d;
        key = {c.clock_source_select[0], c.startup_time_bits};
        hi = c.clock_source_select[3:1];
        d.clock_range_select = c.clock_source_select[3] ? hi : 3'h0;
        if (c.clock_source_select[3] || hi == 3'h3) begin
            unique case (key)
                3'h0: d.oscnt = OC_258;
                3'h1: d.oscnt = OC_258;
                3'h2: d.oscnt = OC_1K;
                3'h3: d.oscnt = OC_1K;
                3'h4: d.oscnt = OC_1K;
                default: d.oscnt = OC_16K;
            endcase
            unique case (key)
                3'h0: d.tout = TO_SHORT;
                3'h1: d.tout = TO_LONG;
                3'h2: d.tout = TO_NONE;
                3'h3: d.tout = TO_SHORT;
                3'h4: d.tout = TO_LONG;
                3'h5: d.tout = TO_NONE;
                3'h6: d.tout = TO_SHORT;
                default: d.tout = TO_LONG;
            endcase
        end else begin
            // Low-frequency crystal uses the low bit; others start in 6 cycles
            if (hi == 3'h2) begin
                d.oscnt = c.clock_source_select[0] ? OC_32K : OC_1K;
            end else begin
                d.oscnt = OC_6;
            end
            // Reserved code 11 falls back to the longest delay
            unique case (c.startup_time_bits)
                2'h0: d.tout = TO_NONE;
                2'h1: d.tout = TO_SHORT;
                default: d.tout = TO_LONG;
            endcase
        end
        return d;
    endfunction : csrs_decode

endpackage : csrs_pkg

//--- csrs_pin_sync.sv
// Two-stage synchroniser with rising-edge detect for a group of pins.
// Assumes each pin stays high and low for at least two reference cycles.
`timescale 1ns/1ns
module csrs_pin_sync #(
    parameter int N = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [N-1:0] pin,
    output logic [N-1:0] level,
    output logic [N-1:0] rise
);
    typedef struct packed {
        logic [N-1:0] meta;
        logic [N-1:0] sync;
        logic [N-1:0] last;
    } csrs_sync_type;

    csrs_sync_type s_r;
    csrs_sync_type s_nxt;

    generate
        if (N < 1) begin : g_chk
            $error("csrs_pin_sync needs at least one pin");
        end
    endgenerate

    always_comb begin
        s_nxt.meta = pin;
        s_nxt.sync = s_r.meta;
        s_nxt.last = s_r.sync;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.sync;
    assign rise = s_r.sync & ~s_r.last;

endmodule : csrs_pin_sync

//--- csrs_tick_counter.sv
// Counts qualified ticks up to a limit and flags completion.
// Assumes the limit stays stable while counting; clear restarts from zero.
`timescale 1ns/1ns
module csrs_tick_counter #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic tick,
    input wire logic [W-1:0] limit,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] count;
        logic done;
    } csrs_cnt_type;

    csrs_cnt_type s_r;
    csrs_cnt_type s_nxt;

    generate
        if (W < 2) begin : g_chk
            $error("csrs_tick_counter width too small");
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        if (clear) begin
            s_nxt.count = '0;
        end else if (tick && !s_r.done) begin
            s_nxt.count = s_r.count + 1'b1;
        end
        // A zero limit completes at once
        s_nxt.done = (s_nxt.count >= limit);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;

endmodule : csrs_tick_counter

//--- csrs_sequencer.sv
// Clock start-up reset sequencer with an AXI4-Lite register slave.
// Assumes oscillators and reset sources arrive as asynchronous pins
// and toggle well below a quarter of the reference clock rate.
// Overview of operation
// - After reset the configuration is RC oscillator, start-up 10, divide-by-8 on.
// - Internal reset stays asserted a time-out after all reset sources release.
// - Time-out counts watchdog oscillator cycles, length picked by source and start-up fields.
// - Time-out lengths are 0, 4096 or 8192 watchdog cycles only.
// - Oscillator edge counter holds reset for the configured count, then releases.
// - Oscillator count ranges from 6 cycles (external) to 32K (low frequency crystal).
// - Start-up from reset runs the time-out, then the oscillator count.
// - Wake from sleep skips the time-out and runs only the oscillator count.
// - Low-power crystal range mode comes from the upper three source-select bits.
// - Codes 0/00 and 0/01: 258 cycles, plus 14 and short or long time-out.
// - Codes 0/10, 0/11, 1/00: 1K cycles, plus 14 and none, short, long.
// - Codes 1/01, 1/10, 1/11: 16K cycles, plus 14 and none, short, long.
// - Time-out may be off when the brownout detector guards supply.
// - With divide-by-eight programmed the system clock is oscillator divided by 8.
// - The time-out is a fixed count and never senses supply voltage.
// - Source-select codes 1111 to 1000 pick the low-power crystal oscillator.
// - A configuration bit at one is unprogrammed, at zero programmed.
`timescale 1ns/1ns
module csrs_sequencer #(
    parameter int ADDR_W = 4,
    parameter int CNT_W = 16,
    parameter int TOUT_SHORT_CYC = csrs_pkg::CSRS_TOUT_SHORT_CYC,
    parameter int TOUT_LONG_CYC = csrs_pkg::CSRS_TOUT_LONG_CYC,
    parameter int OSC_16K_CYC = csrs_pkg::CSRS_OSC_16K_CYC,
    parameter int OSC_32K_CYC = csrs_pkg::CSRS_OSC_32K_CYC
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [3:0] RST_SRC,
    input wire logic WDT_OSC,
    input wire logic SEL_OSC,
    input wire logic WAKE_REQ,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic INT_RESET,
    output logic SYS_CLK_STB,
    output logic CLK_HALT
);
    typedef struct packed {
        csrs_pkg::csrs_state_type state;
        csrs_pkg::csrs_cfg_type cfg_pend;
        csrs_pkg::csrs_cfg_type cfg_act;
        csrs_pkg::csrs_dec_type dec;
        logic [2:0] div;
        logic int_reset;
        logic clk_stb;
        logic clk_halt;
        logic sleep_req;
        logic aw_ok;
        logic [ADDR_W-1:0] aw_addr;
        logic w_ok;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } csrs_top_type;

    csrs_top_type s_r;
    csrs_top_type s_nxt;
    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [3:0] src_sync;
    logic any_src;
    logic tout_clear;
    logic osc_clear;
    logic tout_done;
    logic osc_done;
    logic [CNT_W-1:0] tout_limit;
    logic [CNT_W-1:0] osc_limit;

    generate
        if (ADDR_W < 4 || CNT_W < 16 || OSC_32K_CYC + 14 >= (1 << CNT_W)
                || TOUT_LONG_CYC >= (1 << CNT_W)) begin : g_chk
            $error("csrs_sequencer parameters out of range");
        end
    endgenerate

    // Oscillator counts, with the extra from-reset cycles added on request
    function automatic logic [CNT_W-1:0] osc_count(input csrs_pkg::csrs_oscnt_type o,
                                                  input logic from_reset);
        int n;
        unique case (o)
            csrs_pkg::OC_6: n = csrs_pkg::CSRS_OSC_EXT_CYC;
            csrs_pkg::OC_258: n = csrs_pkg::CSRS_OSC_258_CYC;
            csrs_pkg::OC_1K: n = csrs_pkg::CSRS_OSC_1K_CYC;
            csrs_pkg::OC_16K: n = OSC_16K_CYC;
            default: n = OSC_32K_CYC;
        endcase
        if (from_reset) begin
            n = n + csrs_pkg::CSRS_OSC_RST_EXTRA_CYC;
        end
        return n[CNT_W-1:0];
    endfunction : osc_count

    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                              input csrs_top_type s);
        logic [31:0] v;
        v = 32'h0;
        if (a == csrs_pkg::CSRS_OFS_CONFIG) begin
            v[6:0] = s.cfg_pend;
        end else if (a == csrs_pkg::CSRS_OFS_STATUS) begin
            v[csrs_pkg::CSRS_ST_STATE_POS +: 3] = s.state;
            v[csrs_pkg::CSRS_ST_RST_POS] = s.int_reset;
            v[csrs_pkg::CSRS_ST_RANGE_POS +: 3] = s.dec.clock_range_select;
            v[csrs_pkg::CSRS_ST_TOUT_POS +: 2] = s.dec.tout;
            v[csrs_pkg::CSRS_ST_OSC_POS +: 3] = s.dec.oscnt;
            v[csrs_pkg::CSRS_ST_DIV_POS] = ~s.cfg_act.divide_by_eight_option;
        end
        return v;
    endfunction : read_word

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return a == csrs_pkg::CSRS_OFS_CONFIG || a == csrs_pkg::CSRS_OFS_CONTROL
            || a == csrs_pkg::CSRS_OFS_STATUS;
    endfunction : addr_ok

    // Reset sources, watchdog oscillator, selected oscillator, wake
    csrs_pin_sync #(.N(4)) u_src_sync (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .pin(RST_SRC),
        .level(src_sync),
        .rise()
    );

    csrs_pin_sync #(.N(3)) u_osc_sync (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .pin({WAKE_REQ, SEL_OSC, WDT_OSC}),
        .level(pin_level),
        .rise(pin_rise)
    );

    assign any_src = |src_sync;

    // Watchdog-cycle time-out; pure count, no supply sensing
    csrs_tick_counter #(.W(CNT_W)) u_tout (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .clear(tout_clear),
        .tick(pin_rise[0]),
        .limit(tout_limit),
        .done(tout_done)
    );

    csrs_tick_counter #(.W(CNT_W)) u_osc (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .clear(osc_clear),
        .tick(pin_rise[1]),
        .limit(osc_limit),
        .done(osc_done)
    );

    always_comb begin
        unique case (s_r.dec.tout)
            csrs_pkg::TO_SHORT: tout_limit = CNT_W'(TOUT_SHORT_CYC);
            csrs_pkg::TO_LONG: tout_limit = CNT_W'(TOUT_LONG_CYC);
            default: tout_limit = '0;
        endcase
        osc_limit = osc_count(s_r.dec.oscnt, s_r.state != csrs_pkg::ST_WAKE);
        tout_clear = s_r.state != csrs_pkg::ST_TOUT;
        osc_clear = s_r.state != csrs_pkg::ST_OSC && s_r.state != csrs_pkg::ST_WAKE;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.sleep_req = 1'b0;
        s_nxt.clk_stb = 1'b0;

        // Write address and data taken in either order
        if (AWVALID && s_r.awready) begin
            s_nxt.aw_ok = 1'b1;
            s_nxt.aw_addr = AWADDR;
        end
        if (WVALID && s_r.wready) begin
            s_nxt.w_ok = 1'b1;
            s_nxt.w_data = WDATA;
            s_nxt.w_strb = WSTRB;
        end
        if (BVALID && BREADY) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
            s_nxt.aw_ok = 1'b0;
            s_nxt.w_ok = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = csrs_pkg::CSRS_RESP_OKAY;
            if (!addr_ok(s_r.aw_addr)) begin
                s_nxt.bresp = csrs_pkg::CSRS_RESP_SLVERR;
            end else if (s_r.w_strb[0]) begin
                if (s_r.aw_addr == csrs_pkg::CSRS_OFS_CONFIG) begin
                    s_nxt.cfg_pend = s_r.w_data[6:0];
                end else if (s_r.aw_addr == csrs_pkg::CSRS_OFS_CONTROL) begin
                    s_nxt.sleep_req = s_r.w_data[csrs_pkg::CSRS_CTL_SLEEP_POS];
                end
            end
        end
        s_nxt.awready = !s_nxt.aw_ok && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_ok && !s_nxt.bvalid;

        if (RVALID && RREADY) begin
            s_nxt.rvalid = 1'b0;
        end
        if (ARVALID && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = read_word(ARADDR, s_r);
            s_nxt.rresp = addr_ok(ARADDR) ? csrs_pkg::CSRS_RESP_OKAY
                                          : csrs_pkg::CSRS_RESP_SLVERR;
        end
        s_nxt.arready = !s_nxt.rvalid;

        // Start-up sequence
        unique case (s_r.state)
            csrs_pkg::ST_HOLD: begin
                // Fuses latched here so a later write cannot disturb a sequence
                s_nxt.cfg_act = s_r.cfg_pend;
                s_nxt.dec = csrs_pkg::csrs_decode(s_r.cfg_pend);
                if (!any_src) begin
                    s_nxt.state = csrs_pkg::ST_TOUT;
                end
            end
            csrs_pkg::ST_TOUT: begin
                if (tout_done) begin
                    s_nxt.state = csrs_pkg::ST_OSC;
                end
            end
            csrs_pkg::ST_OSC: begin
                if (osc_done) begin
                    s_nxt.state = csrs_pkg::ST_RUN;
                end
            end
            csrs_pkg::ST_RUN: begin
                if (s_r.sleep_req) begin
                    s_nxt.state = csrs_pkg::ST_SLEEP;
                end
            end
            csrs_pkg::ST_SLEEP: begin
                if (pin_level[2]) begin
                    s_nxt.state = csrs_pkg::ST_WAKE;
                end
            end
            csrs_pkg::ST_WAKE: begin
                if (osc_done) begin
                    s_nxt.state = csrs_pkg::ST_RUN;
                end
            end
            default: begin
                s_nxt.state = csrs_pkg::ST_HOLD;
            end
        endcase
        if (any_src) begin
            s_nxt.state = csrs_pkg::ST_HOLD;
        end

        // System clock strobe, divided by 8 when programmed
        if (s_nxt.state == csrs_pkg::ST_RUN && pin_rise[1]) begin
            s_nxt.div = s_r.div + 3'h1;
            s_nxt.clk_stb = s_r.cfg_act.divide_by_eight_option
                || s_r.div == 3'(csrs_pkg::CSRS_DIV_LAST);
        end
        if (s_nxt.state != csrs_pkg::ST_RUN) begin
            s_nxt.div = 3'h0;
        end
        s_nxt.int_reset = s_nxt.state == csrs_pkg::ST_HOLD
            || s_nxt.state == csrs_pkg::ST_TOUT || s_nxt.state == csrs_pkg::ST_OSC;
        s_nxt.clk_halt = s_nxt.state == csrs_pkg::ST_SLEEP
            || s_nxt.state == csrs_pkg::ST_WAKE;
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            s_r <= '0;
            s_r.state <= csrs_pkg::ST_HOLD;
            s_r.cfg_pend <= csrs_pkg::CSRS_CFG_RESET;
            s_r.cfg_act <= csrs_pkg::CSRS_CFG_RESET;
            s_r.int_reset <= 1'b1;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign AWREADY = s_r.awready;
    assign WREADY = s_r.wready;
    assign BVALID = s_r.bvalid;
    assign BRESP = s_r.bresp;
    assign ARREADY = s_r.arready;
    assign RVALID = s_r.rvalid;
    assign RDATA = s_r.rdata;
    assign RRESP = s_r.rresp;
    assign INT_RESET = s_r.int_reset;
    assign SYS_CLK_STB = s_r.clk_stb;
    assign CLK_HALT = s_r.clk_halt;

endmodule : csrs_sequencer

//--- csrs_sequencer_monitor.sv
// Checker for the start-up reset sequencer, bound to its top module.
// Assumes oscillator pins stay high and low for several reference cycles.
`timescale 1ns/1ns
module csrs_sequencer_monitor (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [3:0] RST_SRC,
    input wire logic SEL_OSC,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic INT_RESET,
    input wire logic SYS_CLK_STB,
    input wire logic CLK_HALT
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);

    // Cycles since a raw oscillator rise; saturates so it never wraps
    logic sel_q_r;
    logic [3:0] since_sel_r;
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            sel_q_r <= 1'b0;
            since_sel_r <= 4'hf;
        end else begin
            sel_q_r <= SEL_OSC;
            if (SEL_OSC && !sel_q_r) begin
                since_sel_r <= 4'h0;
            end else if (since_sel_r != 4'hf) begin
                since_sel_r <= since_sel_r + 4'h1;
            end
        end
    end

    a_src_forces_reset: assert property ((RST_SRC != 4'h0) [*4] |-> INT_RESET)
        else $error("internal reset low while a source is active");
    a_release_src_idle: assert property ($fell(INT_RESET) |->
        $past(RST_SRC, 3) == 4'h0 && $past(RST_SRC, 4) == 4'h0)
        else $error("internal reset released with a source active");
    a_release_after_osc: assert property ($fell(INT_RESET) |-> since_sel_r < 4'hc)
        else $error("internal reset released without an oscillator edge");
    a_wake_after_osc: assert property ($fell(CLK_HALT) |-> since_sel_r < 4'hc)
        else $error("wake finished without an oscillator edge");
    a_halt_not_reset: assert property (CLK_HALT |-> !INT_RESET)
        else $error("internal reset during wake");
    a_strobe_only_run: assert property (SYS_CLK_STB |-> !INT_RESET && !CLK_HALT)
        else $error("system clock strobe outside run");
    a_strobe_single: assert property (SYS_CLK_STB |=> !SYS_CLK_STB)
        else $error("system clock strobe wider than one cycle");
    a_write_resp_lat: assert property ((AWVALID && AWREADY && WVALID && WREADY) |-> ##2 BVALID)
        else $error("write response late");
    a_read_resp_lat: assert property ((ARVALID && ARREADY) |=> RVALID)
        else $error("read data late");
    a_read_resp_done: assert property ((RVALID && RREADY) |=> !RVALID && ARREADY)
        else $error("read data not retired");

    cover property ($fell(INT_RESET));
    cover property ($fell(CLK_HALT));
    cover property (BVALID && BREADY);
endmodule : csrs_sequencer_monitor

bind csrs_sequencer csrs_sequencer_monitor csrs_sequencer_monitor_i (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .RST_SRC(RST_SRC), .SEL_OSC(SEL_OSC),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
    .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RVALID(RVALID), .RREADY(RREADY), .INT_RESET(INT_RESET),
    .SYS_CLK_STB(SYS_CLK_STB), .CLK_HALT(CLK_HALT));

//--- csrs_sequencer_test.sv
// Self-checking bench for the start-up reset sequencer.
// Assumes shortened counts: 16 watchdog rises for the long time-out.
`timescale 1ns/1ns
module csrs_sequencer_test;
    localparam logic [3:0] OCFG = csrs_pkg::CSRS_OFS_CONFIG;
    localparam logic [3:0] OST = csrs_pkg::CSRS_OFS_STATUS;
    localparam int TLONG = 16;
    localparam int ORC = csrs_pkg::CSRS_OSC_EXT_CYC;
    localparam int OADD = csrs_pkg::CSRS_OSC_RST_EXTRA_CYC;
    logic ref_clk, sys_rst, wdt_osc, sel_osc, wake_req;
    logic [3:0] rst_src, awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, int_reset, sys_clk_stb, clk_halt;
    int n_mismatch, n_compared, n_stb;

    csrs_sequencer #(.TOUT_SHORT_CYC(8), .TOUT_LONG_CYC(TLONG), .OSC_16K_CYC(20),
        .OSC_32K_CYC(24)) csrs_sequencer_i (
        .REF_CLK(ref_clk), .SYS_RST(sys_rst), .RST_SRC(rst_src), .WDT_OSC(wdt_osc),
        .SEL_OSC(sel_osc), .WAKE_REQ(wake_req), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .INT_RESET(int_reset),
        .SYS_CLK_STB(sys_clk_stb), .CLK_HALT(clk_halt));

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s: expected %b, seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic conclude;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        bit got;
        got = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(posedge ref_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                got = 1;
            end
        end
    endtask : wr

    task automatic rd(input logic [3:0] a);
        bit got;
        got = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            @(posedge ref_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                got = 1;
            end
        end
    endtask : rd

    // Each rise held 4 cycles so the synchroniser never misses it
    task automatic pulses(input bit sel, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            if (sel) sel_osc <= 1'b1;
            else wdt_osc <= 1'b1;
            repeat (4) @(posedge ref_clk);
            sel_osc <= 1'b0;
            wdt_osc <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask : pulses

    task automatic t_defaults;
        rd(OCFG);
        chk_word("config", 32'h22, d);
        rd(OST);
        chk_word("status", 32'h1108, d & 32'h1fff);
        rd(4'hc);
        chk_word("bad read resp", {30'h0, csrs_pkg::CSRS_RESP_SLVERR}, {30'h0, r});
        chk_word("bad read data", 32'h0, d);
        wr(4'hc, 32'hffffffff);
        chk_word("bad write resp", {30'h0, csrs_pkg::CSRS_RESP_SLVERR}, {30'h0, r});
    endtask : t_defaults

    // Every low-power crystal code, walking the range modes alongside
    task automatic t_decode;
        logic [6:0] cfg;
        logic [2:0] osc;
        logic [1:0] tout;
        for (int k = 0; k < 8; k++) begin
            cfg = {k[0], k[1:0], 1'b1, k[1:0], k[2]};
            osc = (k < 2) ? 3'h1 : (k < 5) ? 3'h2 : 3'h3;
            tout = (k % 3 == 0) ? 2'h1 : (k % 3 == 1) ? 2'h2 : 2'h0;
            wr(OCFG, {25'h0, cfg});
            rd(OST);
            chk_word("decode", {19'h0, ~cfg[6], osc, tout, cfg[3:1], 4'h8}, d & 32'h1fff);
        end
    endtask : t_decode

    task automatic t_startup;
        wr(OCFG, 32'h22);
        rst_src <= 4'h0;
        pulses(1'b0, 8);
        rst_src <= 4'h4;
        repeat (6) @(posedge ref_clk);
        rst_src <= 4'h0;
        pulses(1'b0, TLONG - 1);
        pulses(1'b1, ORC + OADD);
        chk_bit("reset in time-out", 1'b1, int_reset);
        pulses(1'b0, 1);
        repeat (4) @(posedge ref_clk);
        rd(OST);
        chk_word("state after time-out", 32'h2, d & 32'h7);
        pulses(1'b1, ORC + OADD - 1);
        repeat (6) @(posedge ref_clk);
        chk_bit("reset one edge short", 1'b1, int_reset);
        pulses(1'b1, 1);
        repeat (4) @(posedge ref_clk);
        chk_bit("reset released", 1'b0, int_reset);
    endtask : t_startup

    task automatic t_sleep_wake;
        wr(csrs_pkg::CSRS_OFS_CONTROL, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk_bit("halt in sleep", 1'b1, clk_halt);
        wake_req <= 1'b1;
        repeat (6) @(posedge ref_clk);
        pulses(1'b1, ORC - 1);
        repeat (4) @(posedge ref_clk);
        chk_bit("halt one edge short", 1'b1, clk_halt);
        chk_bit("no reset on wake", 1'b0, int_reset);
        pulses(1'b1, 1);
        repeat (4) @(posedge ref_clk);
        chk_bit("halt after wake", 1'b0, clk_halt);
        wake_req <= 1'b0;
    endtask : t_sleep_wake

    task automatic t_divider;
        int c0;
        c0 = n_stb;
        pulses(1'b1, 16);
        repeat (4) @(posedge ref_clk);
        chk_word("strobes per 16 rises", 32'h2, n_stb - c0);
        wr(OCFG, 32'h42);
        rst_src <= 4'h1;
        pulses(1'b0, 1);
        rst_src <= 4'h0;
        pulses(1'b0, 1);
        pulses(1'b1, ORC + OADD + 8);
        chk_word("undivided strobes", 32'h8, n_stb - c0 - 2);
    endtask : t_divider

    always @(posedge ref_clk) begin
        if (sys_clk_stb === 1'b1) n_stb++;
    end

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        {sys_rst, rst_src, wstrb} = 9'h11f;
        {wdt_osc, sel_osc, wake_req, awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        n_mismatch = 0;
        n_compared = 0;
        n_stb = 0;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_defaults();
        t_decode();
        t_startup();
        t_sleep_wake();
        t_divider();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end
endmodule : csrs_sequencer_test
